// [t1lic_pkg.sv]
// Function
// - while the force-loss bit 7 is set the transmit line carries the loss-of-signal pattern (no pulses), otherwise normal traffic.
// - loopback select 00 in bits 5:4 is normal mode with no loopback path active.
// - loopback select 01 sends transmit PCM data to the receive PCM output, ignores the receive line and sends all ones to the line.
// - loopback select 10 sends decoded receive line data straight back through the encoder to the line, bypassing the framer.
// - loopback select 11 feeds received time-slot data into the transmit framer, which re-times it on transmit timing.
// - transmit encode bit 1 at 0 applies zero-substitution encoding in dual-rail mode only (single-rail bit 6 clear), and at 1 sends plain AMI.
// - receive decode bit 0 at 0 applies zero-substitution decoding in dual-rail mode only (single-rail bit 6 clear), and at 1 takes the line as plain AMI.
package t1lic_pkg;

   // register indices and byte addresses
   localparam logic [11:0] CTRL_IDX = 12'h101;
   localparam logic [11:0] STAT_IDX = 12'h102;
   localparam logic [11:0] CTRL_ADDR = {CTRL_IDX[9:0], 2'h0};
   localparam logic [11:0] STAT_ADDR = {STAT_IDX[9:0], 2'h0};

   // control field positions and reset value
   localparam int unsigned FORCE_LOSS_BIT = 7;
   localparam int unsigned SINGLE_RAIL_BIT = 6;
   localparam int unsigned LOOPBACK_LSB = 4;
   localparam int unsigned RSVD_LSB = 2;
   localparam int unsigned TX_AMI_BIT = 1;
   localparam int unsigned RX_AMI_BIT = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // status field positions
   localparam int unsigned STAT_FULL_BIT = 8;
   localparam int unsigned STAT_EMPTY_BIT = 9;

   // loopback select codes
   localparam logic [1:0] LOOP_NORMAL = 2'h0;
   localparam logic [1:0] LOOP_LOCAL = 2'h1;
   localparam logic [1:0] LOOP_FAR_END = 2'h2;
   localparam logic [1:0] LOOP_PAYLOAD = 2'h3;

   // transmit symbol codes in the encoder delay line
   localparam logic [1:0] SYM_ZERO = 2'h0;
   localparam logic [1:0] SYM_ONE = 2'h1;
   localparam logic [1:0] SYM_VIOL = 2'h2;
   localparam logic [1:0] SYM_BIPOL = 2'h3;
   // 000VB0VB, oldest symbol in the low slot
   localparam logic [15:0] SUBST_PATTERN = 16'he380;
   localparam int unsigned CODE_DEPTH = 8;

   // transmit PCM buffer
   localparam int unsigned FIFO_WIDTH = 1;
   localparam int unsigned FIFO_DEPTH = 16;

   typedef struct packed {
      logic force_signal_loss_pattern;
      logic single_rail_select;
      logic [1:0] framer_loopback_select;
      logic [1:0] rsvd;
      logic tx_ami;
      logic rx_ami;
   } t1lic_ctrl_t;

   typedef struct packed {
      logic pos;
      logic neg;
   } t1lic_sym_t;

endpackage : t1lic_pkg

// [t1lic_fifo.sv]
module t1lic_fifo import t1lic_pkg::*; #(
   parameter int unsigned WIDTH = FIFO_WIDTH,
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } t1lic_fifo_state_t;

   t1lic_fifo_state_t s_ff;
   t1lic_fifo_state_t nxt_s;
   logic push;
   logic pop;

   assign in_ready = (s_ff.count != DEPTH[AW:0]);
   assign out_valid = (s_ff.count != '0);
   assign out_data = s_ff.mem[s_ff.rd_ptr];
   assign level = s_ff.count;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      nxt_s = s_ff;
      if (push) begin
         nxt_s.mem[s_ff.wr_ptr] = in_data;
         nxt_s.wr_ptr = s_ff.wr_ptr + 1'b1;
      end
      if (pop) begin
         nxt_s.rd_ptr = s_ff.rd_ptr + 1'b1;
      end
      nxt_s.count = s_ff.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

endmodule : t1lic_fifo

// [t1lic_codec.sv]
module t1lic_codec import t1lic_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // line bit strobe and mode
   input wire logic tick,
   input wire logic tx_ami,
   input wire logic rx_ami,
   input wire logic single_rail,
   // transmit side
   input wire logic tx_bit,
   output t1lic_sym_t tx_sym,
   // receive side
   input wire t1lic_sym_t rx_sym,
   output logic rx_bit
);
   typedef struct packed {
      logic [CODE_DEPTH-1:0][1:0] enc_c;
      logic enc_last;
      t1lic_sym_t tx;
      logic [CODE_DEPTH-1:0] dec_p;
      logic [CODE_DEPTH-1:0] dec_n;
      logic rx_bit;
   } t1lic_codec_state_t;

   t1lic_codec_state_t s_ff;
   t1lic_codec_state_t nxt_s;
   logic [1:0] code;
   logic sub_hit;
   logic dec_hit;

   // detect a received 000VB0VB window, oldest symbol in bit 0
   function automatic logic subst_match(input logic [7:0] p, input logic [7:0] n);
      logic quiet;
      quiet = !(p[0] | n[0] | p[1] | n[1] | p[2] | n[2] | p[5] | n[5]);
      subst_match = quiet && ((p[3] && n[4] && n[6] && p[7]) || (n[3] && p[4] && p[6] && n[7]));
   endfunction : subst_match

   assign tx_sym = s_ff.tx;
   assign rx_bit = s_ff.rx_bit;

   always_comb begin
      nxt_s = s_ff;
      code = s_ff.enc_c[0];
      sub_hit = 1'b0;
      dec_hit = 1'b0;
      if (tick) begin
         nxt_s.tx = '0;
         if (single_rail) begin
            nxt_s.tx.pos = (code != SYM_ZERO);
         end else begin
            case (code)
               SYM_ONE, SYM_BIPOL: begin
                  nxt_s.tx.pos = !s_ff.enc_last;
                  nxt_s.tx.neg = s_ff.enc_last;
                  nxt_s.enc_last = !s_ff.enc_last;
               end
               SYM_VIOL: begin
                  nxt_s.tx.pos = s_ff.enc_last;
                  nxt_s.tx.neg = !s_ff.enc_last;
               end
               default: begin
               end
            endcase
         end
         nxt_s.enc_c = {(tx_bit ? SYM_ONE : SYM_ZERO), s_ff.enc_c[CODE_DEPTH-1:1]};
         sub_hit = !tx_ami && !single_rail && (nxt_s.enc_c == '0);
         if (sub_hit) begin
            nxt_s.enc_c = SUBST_PATTERN;
         end
         nxt_s.rx_bit = s_ff.dec_p[0] | s_ff.dec_n[0];
         nxt_s.dec_p = {rx_sym.pos, s_ff.dec_p[CODE_DEPTH-1:1]};
         nxt_s.dec_n = {rx_sym.neg && !single_rail, s_ff.dec_n[CODE_DEPTH-1:1]};
         dec_hit = !rx_ami && !single_rail && subst_match(nxt_s.dec_p, nxt_s.dec_n);
         if (dec_hit) begin
            nxt_s.dec_p = '0;
            nxt_s.dec_n = '0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   a_enc_subst_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sub_hit |=> (s_ff.enc_c[3] == SYM_VIOL) && (s_ff.enc_c[7] == SYM_BIPOL))
      else $error("zero run not replaced by substitution pattern");

   a_enc_ami_plain: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (tick && tx_ami) |=> (s_ff.enc_c[7] == ($past(tx_bit) ? SYM_ONE : SYM_ZERO)))
      else $error("plain AMI encoder inserted a substitution symbol");

   a_dec_subst_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dec_hit |=> (s_ff.dec_p == '0) && (s_ff.dec_n == '0))
      else $error("received substitution pattern not decoded to zeros");

   a_dec_ami_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (tick && rx_ami) |=> s_ff.dec_p[CODE_DEPTH-1] == $past(rx_sym.pos))
      else $error("plain AMI decoder altered received pulses");

endmodule : t1lic_codec

// [t1lic_top.sv]
module t1lic_top import t1lic_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // transmit pcm input
   input wire logic tx_pcm_valid,
   output logic tx_pcm_ready,
   input wire logic tx_pcm_bit,
   // line bit timing strobe
   input wire logic line_bit_tick,
   // receive line pair from the line interface unit
   input wire logic rx_line_pos,
   input wire logic rx_line_neg,
   // transmit line pair
   output logic tx_line_pos,
   output logic tx_line_neg,
   // receive pcm output
   output logic rx_pcm_bit,
   output logic rx_pcm_valid,
   // single-rail select toward the line interface
   output logic single_rail_select
);
   typedef struct packed {
      t1lic_ctrl_t ctrl;
      t1lic_sym_t rx_s1;
      t1lic_sym_t rx_s2;
      logic [31:0] prdata;
      t1lic_sym_t tx;
      logic pay_bit;
      logic rx_bit;
      logic rx_valid;
   } t1lic_top_state_t;

   t1lic_top_state_t s_ff;
   t1lic_top_state_t nxt_s;
   logic [1:0] rst_sync_ff;
   logic rst_n;

   logic fifo_out_valid;
   logic fifo_out_ready;
   logic fifo_out_data;
   logic [4:0] fifo_level;
   logic codec_tx_bit;
   t1lic_sym_t codec_tx_sym;
   t1lic_sym_t codec_rx_sym;
   logic dec_bit;
   logic [1:0] lpbk;
   logic pcm_bit;
   logic wr_ctrl;
   logic setup_rd;
   logic mapped;

   // reset release through two flops
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   assign lpbk = s_ff.ctrl.framer_loopback_select;
   assign pcm_bit = fifo_out_valid ? fifo_out_data : 1'b1;

   // pcm buffer drained one bit per line bit in normal and local modes
   assign fifo_out_ready = line_bit_tick && ((lpbk == LOOP_NORMAL) || (lpbk == LOOP_LOCAL));

   t1lic_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_valid(tx_pcm_valid),
      .in_ready(tx_pcm_ready),
      .in_data(tx_pcm_bit),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   // transmit source per loopback mode
   always_comb begin
      case (lpbk)
         LOOP_LOCAL: codec_tx_bit = 1'b1;
         LOOP_FAR_END: codec_tx_bit = dec_bit;
         LOOP_PAYLOAD: codec_tx_bit = s_ff.pay_bit;
         default: codec_tx_bit = pcm_bit;
      endcase
   end

   // receive line is ignored in local loopback
   assign codec_rx_sym = (lpbk == LOOP_LOCAL) ? t1lic_sym_t'(2'h0) : s_ff.rx_s2;

   t1lic_codec u_codec (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick(line_bit_tick),
      .tx_ami(s_ff.ctrl.tx_ami),
      .rx_ami(s_ff.ctrl.rx_ami),
      .single_rail(s_ff.ctrl.single_rail_select),
      .tx_bit(codec_tx_bit),
      .tx_sym(codec_tx_sym),
      .rx_sym(codec_rx_sym),
      .rx_bit(dec_bit)
   );

   // register address match
   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] reg_addr);
      addr_is = (a == reg_addr);
   endfunction : addr_is

   // apb decode
   assign mapped = addr_is(paddr, CTRL_ADDR) || addr_is(paddr, STAT_ADDR);
   assign wr_ctrl = psel && penable && pwrite && addr_is(paddr, CTRL_ADDR);
   assign setup_rd = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = s_ff.prdata;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.rx_s1.pos = rx_line_pos;
      nxt_s.rx_s1.neg = rx_line_neg;
      nxt_s.rx_s2 = s_ff.rx_s1;
      if (wr_ctrl) begin
         nxt_s.ctrl = t1lic_ctrl_t'(pwdata[7:0]);
      end
      if (setup_rd) begin
         nxt_s.prdata = 32'h0;
         if (addr_is(paddr, CTRL_ADDR)) begin
            nxt_s.prdata[7:0] = s_ff.ctrl;
         end else if (addr_is(paddr, STAT_ADDR)) begin
            nxt_s.prdata[4:0] = fifo_level;
            nxt_s.prdata[STAT_FULL_BIT] = !tx_pcm_ready;
            nxt_s.prdata[STAT_EMPTY_BIT] = !fifo_out_valid;
         end
      end
      nxt_s.rx_valid = line_bit_tick;
      if (line_bit_tick) begin
         nxt_s.pay_bit = dec_bit;
         nxt_s.rx_bit = (lpbk == LOOP_LOCAL) ? pcm_bit : dec_bit;
      end
      if (s_ff.ctrl.force_signal_loss_pattern) begin
         nxt_s.tx = '0;
      end else begin
         nxt_s.tx = codec_tx_sym;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '0;
         s_ff.ctrl <= CTRL_RESET;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign tx_line_pos = s_ff.tx.pos;
   assign tx_line_neg = s_ff.tx.neg;
   assign rx_pcm_bit = s_ff.rx_bit;
   assign rx_pcm_valid = s_ff.rx_valid;
   assign single_rail_select = s_ff.ctrl.single_rail_select;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   a_force_loss_quiet: assert property (
      s_ff.ctrl.force_signal_loss_pattern |=> !tx_line_pos && !tx_line_neg)
      else $error("line pulses sent while loss pattern forced");

   a_normal_traffic: assert property (
      !s_ff.ctrl.force_signal_loss_pattern |=> {tx_line_pos, tx_line_neg} == $past(codec_tx_sym))
      else $error("normal traffic not sent to line");

   a_normal_rx_path: assert property (
      (lpbk == LOOP_NORMAL && line_bit_tick) |=> rx_pcm_valid && rx_pcm_bit == $past(dec_bit))
      else $error("normal mode receive pcm not from decoder");

   a_normal_tx_src: assert property (
      (lpbk == LOOP_NORMAL) |-> codec_tx_bit == pcm_bit)
      else $error("normal mode transmit not from pcm input");

   a_normal_drain: assert property (
      (lpbk == LOOP_NORMAL) |-> fifo_out_ready == line_bit_tick)
      else $error("normal mode pcm buffer not drained per bit");

   a_local_loop_data: assert property (
      (lpbk == LOOP_LOCAL && line_bit_tick) |=> rx_pcm_bit == $past(pcm_bit))
      else $error("local loopback pcm data not returned");

   a_local_all_ones: assert property (
      (lpbk == LOOP_LOCAL) |-> codec_tx_bit && codec_rx_sym == t1lic_sym_t'(2'h0))
      else $error("local loopback not sending all ones");

   a_far_end_loop: assert property (
      (lpbk == LOOP_FAR_END) |-> codec_tx_bit == dec_bit && !fifo_out_ready)
      else $error("far-end loopback path broken");

   a_payload_loop: assert property (
      (lpbk == LOOP_PAYLOAD && line_bit_tick) |=> ##0 (codec_tx_bit == $past(dec_bit) || lpbk != LOOP_PAYLOAD))
      else $error("payload loopback did not re-time received data");

   a_payload_src: assert property (
      (lpbk == LOOP_PAYLOAD) |-> codec_tx_bit == s_ff.pay_bit && !fifo_out_ready)
      else $error("payload loopback not fed from re-timing register");

   a_reset_zero: assert property (
      $rose(rst_n) |-> s_ff.ctrl == CTRL_RESET)
      else $error("control not zero after reset");

   a_rsvd_readback: assert property (
      wr_ctrl |=> s_ff.ctrl.rsvd == $past(pwdata[3:2]) && s_ff.ctrl == $past(pwdata[7:0]))
      else $error("control write not stored as written");

   a_ctrl_read: assert property (
      (setup_rd && addr_is(paddr, CTRL_ADDR)) |=> prdata == {24'h0, $past(s_ff.ctrl)})
      else $error("control read data wrong");

   a_unmapped_keep: assert property (
      (psel && penable && pwrite && !mapped) |=> $stable(s_ff.ctrl))
      else $error("unmapped write changed control");

   a_single_rail_out: assert property (
      wr_ctrl |=> single_rail_select == $past(pwdata[SINGLE_RAIL_BIT]))
      else $error("single-rail select not driven from control");

   a_unmapped_err: assert property (
      (psel && penable) |-> pslverr == !mapped)
      else $error("slave error does not match address decode");

   a_no_wait: assert property (
      (psel && penable) |-> pready)
      else $error("access phase stretched");

   a_stat_read: assert property (
      (setup_rd && addr_is(paddr, STAT_ADDR)) |=> prdata[4:0] == $past(fifo_level))
      else $error("status read level wrong");

   a_rx_valid_pulse: assert property (
      rx_pcm_valid == $past(line_bit_tick))
      else $error("receive pcm valid not one cycle after bit strobe");

   a_rails_exclusive: assert property (
      !(tx_line_pos && tx_line_neg))
      else $error("both transmit rails high");

endmodule : t1lic_top

// [t1lic_liu_model.sv]
module t1lic_liu_model import t1lic_pkg::*; (
   // clock and line bit timing
   input wire logic clk_sys,
   input wire logic tick,
   // line behaviour select
   input wire logic echo,
   input wire logic single_rail,
   input wire logic data_bit,
   // transmit line from the framer
   input wire logic tx_pos,
   input wire logic tx_neg,
   // receive line toward the framer
   output logic rx_pos,
   output logic rx_neg
);
   logic polarity;

   initial begin
      rx_pos = 1'b0;
      rx_neg = 1'b0;
      polarity = 1'b0;
   end

   // one line symbol per bit time, echo loops the line back
   always @(posedge clk_sys) begin
      if (tick) begin
         if (echo) begin
            rx_pos <= tx_pos;
            rx_neg <= tx_neg;
         end else if (single_rail) begin
            rx_pos <= data_bit;
            rx_neg <= 1'b0;
         end else begin
            rx_pos <= data_bit & ~polarity;
            rx_neg <= data_bit & polarity;
            polarity <= polarity ^ data_bit;
         end
      end
   end
endmodule : t1lic_liu_model

// [t1_line_interface_control_tb.sv]
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, b); end end

module t1_line_interface_control_tb import t1lic_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic tx_pcm_valid, tx_pcm_ready, tx_pcm_bit, line_bit_tick, rerr;
   logic rx_line_pos, rx_line_neg, tx_line_pos, tx_line_neg;
   logic rx_pcm_bit, rx_pcm_valid, single_rail_select, echo, lsr, ldata;
   int mismatches, tests_run, pulses, zeros, gap, negs, run;

   t1lic_top DUT (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_pcm_valid(tx_pcm_valid), .tx_pcm_ready(tx_pcm_ready),
      .tx_pcm_bit(tx_pcm_bit), .line_bit_tick(line_bit_tick), .rx_line_pos(rx_line_pos),
      .rx_line_neg(rx_line_neg), .tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg),
      .rx_pcm_bit(rx_pcm_bit), .rx_pcm_valid(rx_pcm_valid),
      .single_rail_select(single_rail_select));

   t1lic_liu_model liu (.clk_sys(clk_sys), .tick(line_bit_tick), .echo(echo),
      .single_rail(lsr), .data_bit(ldata), .tx_pos(tx_line_pos), .tx_neg(tx_line_neg),
      .rx_pos(rx_line_pos), .rx_neg(rx_line_neg));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task print_verdict;
      if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   // one apb transfer, waits for pready under a bound
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         mismatches++;
         print_verdict();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task push(input int n, input logic b);
      int i, k;
      @(posedge clk_sys);
      tx_pcm_valid <= 1'b1;
      tx_pcm_bit <= b;
      k = 0;
      for (i = 0; i < 200 && k < n; i++) begin
         @(posedge clk_sys);
         if (tx_pcm_ready === 1'b1) k++;
      end
      tx_pcm_valid <= 1'b0;
      if (k < n) begin
         mismatches++;
         print_verdict();
      end
      #1;
   endtask : push

   // runs n bit times, counting line pulses and received zeros and measuring the longest silent stretch
   task ticks(input int n);
      pulses = 0;
      zeros = 0;
      gap = 0;
      negs = 0;
      run = 0;
      repeat (n) begin
         @(posedge clk_sys);
         line_bit_tick <= 1'b1;
         @(posedge clk_sys);
         line_bit_tick <= 1'b0;
         #1 if (rx_pcm_valid === 1'b1 && rx_pcm_bit === 1'b0) zeros++;
         @(posedge clk_sys);
         @(posedge clk_sys);
         #1 if (tx_line_pos === 1'b1 || tx_line_neg === 1'b1) begin
            pulses++;
            run = 0;
         end else begin
            run++;
            if (run > gap) gap = run;
         end
         if (tx_line_neg === 1'b1) negs++;
      end
   endtask : ticks

   task s_regs;
      apb(1'b0, CTRL_ADDR, 32'h0);
      `CHK(rdat, 32'h0)
      `CHK(single_rail_select, 1'b0)
      apb(1'b1, CTRL_ADDR, 32'h0000_000c);
      apb(1'b0, CTRL_ADDR, 32'h0);
      `CHK(rdat, 32'h0000_000c)
      apb(1'b0, 12'h7fc, 32'h0);
      `CHK({rerr, rdat}, 33'h1_0000_0000)
   endtask : s_regs

   task s_force;
      apb(1'b1, CTRL_ADDR, 32'h83);
      ticks(12);
      ticks(16);
      `CHK(pulses, 16'd0)
      apb(1'b1, CTRL_ADDR, 32'h0f);
      ticks(12);
      ticks(16);
      `CHK(pulses, 16'd16)
      `CHK(negs, 8)
   endtask : s_force

   // 16 zeros through the coder, looped back by the line model
   task s_code(input logic [7:0] c, input logic sr, input int rx0, input logic longgap);
      lsr <= sr;
      echo <= 1'b1;
      apb(1'b1, CTRL_ADDR, {24'h0, c});
      ticks(12);
      push(16, 1'b0);
      ticks(60);
      `CHK(zeros, rx0)
      `CHK(gap >= 8, longgap)
      if (sr) begin
         `CHK({single_rail_select, negs[0]}, 2'b10)
      end
   endtask : s_code

   task s_loop(input logic [1:0] lpbk);
      echo <= 1'b0;
      ldata <= 1'b0;
      apb(1'b1, CTRL_ADDR, {26'h0, lpbk, 4'h3});
      ticks(20);
      ticks(16);
      `CHK(pulses, 0)
      ldata <= 1'b1;
      ticks(20);
      ticks(16);
      `CHK({pulses, negs}, {32'd16, 32'd8})
   endtask : s_loop

   task s_fifo;
      apb(1'b1, CTRL_ADDR, 32'h23);
      push(16, 1'b0);
      `CHK(tx_pcm_ready, 1'b0)
      apb(1'b0, STAT_ADDR, 32'h0);
      `CHK(rdat[9:0], 10'h110)
      echo <= 1'b0;
      ldata <= 1'b0;
      apb(1'b1, CTRL_ADDR, 32'h13);
      ticks(40);
      `CHK(zeros, 16)
      ticks(16);
      `CHK(pulses, 16)
      apb(1'b0, STAT_ADDR, 32'h0);
      `CHK(rdat[9:0], 10'h200)
   endtask : s_fifo

   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      tx_pcm_valid = 1'b0;
      tx_pcm_bit = 1'b0;
      line_bit_tick = 1'b0;
      echo = 1'b0;
      lsr = 1'b0;
      ldata = 1'b1;
      mismatches = 0;
      tests_run = 0;
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      s_regs();
      s_force();
      s_code(8'h00, 1'b0, 16, 1'b0);
      s_code(8'h01, 1'b0, 8, 1'b0);
      s_code(8'h03, 1'b0, 16, 1'b1);
      s_code(8'h43, 1'b1, 16, 1'b1);
      apb(1'b1, CTRL_ADDR, 32'h03);
      lsr <= 1'b0;
      s_loop(LOOP_FAR_END);
      s_loop(LOOP_PAYLOAD);
      s_fifo();
      print_verdict();
   end
endmodule : t1_line_interface_control_tb
